// file: hdl/edhc_dma_host_ctrl.sv
// dma host control: apb registers, process states, poll demand, bus arbitration
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module edhc_dma_host_ctrl
  import edhc_pkg::*;
#(
  parameter int unsigned POLL_TICK_CYC = EDHC_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  input  wire logic        rx_desc_avail,
  input  wire logic        tx_desc_avail,
  input  wire logic        rx_list_empty,
  input  wire logic        tx_list_empty,
  input  wire logic        rx_desc_step,
  input  wire logic        tx_desc_step,
  input  wire logic        rx_desc_chained,
  input  wire logic        tx_desc_chained,
  input  wire logic [31:0] rx_chain_addr,
  input  wire logic [31:0] tx_chain_addr,
  input  wire logic        rx_bus_req,
  input  wire logic        tx_bus_req,
  input  wire logic        tx_in_progress,
  output var  logic        rx_bus_gnt,
  output var  logic        tx_bus_gnt,
  output var  logic [31:0] rx_fetch_addr,
  output var  logic [31:0] tx_fetch_addr,
  output var  logic        rx_poll_check,
  output var  logic        tx_poll_check,
  output var  logic [2:0]  rx_proc_state,
  output var  logic [2:0]  tx_proc_state,
  output var  logic [1:0]  cache_align,
  output var  logic [4:0]  descriptor_gap_longwords,
  output var  logic        dma_soft_reset
);

  // apb slave, one wait state
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [31:0] rd_val;
  logic        rd_err;
  logic        wr_en;

  logic [31:0] bus_mode_ff;
  logic [31:0] rx_base_ff;
  logic [31:0] tx_base_ff;
  logic [3:0]  om_ff;
  logic [1:0]  st_ff;
  logic [1:0]  mask_ff;
  logic        soft_rst_ff;
  logic        irq_ff;
  logic [1:0]  gnt_ff;
  logic [1:0]  nxt_gnt;
  logic        last_rx_ff;
  logic [15:0] tick_cnt_ff;
  logic [14:0] ap_cnt_ff;
  logic [14:0] ap_ticks;
  logic        auto_poll_ff;
  logic        tick;

  // index 0 receive, index 1 transmit
  logic [1:0]       start;
  logic [1:0]       poll_wr;
  logic [1:0]       poll_dem;
  logic [1:0]       desc_avail;
  logic [1:0]       list_empty;
  logic [1:0]       step;
  logic [1:0]       chained;
  logic [1:0][31:0] chain_addr;
  logic [1:0][31:0] base;
  logic [1:0][31:0] fetch_addr;
  logic [1:0][2:0]  proc_state;
  logic [1:0]       poll_chk;
  logic [1:0]       unavail_evt;

  assign wr_en = psel & penable & pwrite & pready_ff;

  assign start      = {om_ff[1], om_ff[0]};
  assign poll_wr    = {wr_en & (paddr == EDHC_OFS_TX_POLL), wr_en & (paddr == EDHC_OFS_RX_POLL)};
  assign poll_dem   = poll_wr | {auto_poll_ff, 1'b0};
  assign desc_avail = {tx_desc_avail, rx_desc_avail};
  assign list_empty = {tx_list_empty, rx_list_empty};
  assign step       = {tx_desc_step, rx_desc_step};
  assign chained    = {tx_desc_chained, rx_desc_chained};
  assign chain_addr = {tx_chain_addr, rx_chain_addr};
  assign base       = {tx_base_ff, rx_base_ff};

  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      EDHC_OFS_BUS_MODE: rd_val = bus_mode_ff;
      EDHC_OFS_TX_POLL:  rd_val = EDHC_POLL_RD_VAL;
      EDHC_OFS_RX_POLL:  rd_val = EDHC_POLL_RD_VAL;
      EDHC_OFS_RX_BASE:  rd_val = rx_base_ff;
      EDHC_OFS_TX_BASE:  rd_val = tx_base_ff;
      EDHC_OFS_STATUS: begin
        rd_val[EDHC_ST_RX_UNAVAIL]     = st_ff[0];
        rd_val[EDHC_ST_TX_UNAVAIL]     = st_ff[1];
        rd_val[EDHC_ST_RX_STATE +: 3]  = proc_state[0][0] ? EDHC_PS_STOP_CODE :
                                         proc_state[0][1] ? EDHC_PS_RUN_CODE : EDHC_PS_SUSP_CODE;
        rd_val[EDHC_ST_TX_STATE +: 3]  = proc_state[1][0] ? EDHC_PS_STOP_CODE :
                                         proc_state[1][1] ? EDHC_PS_RUN_CODE : EDHC_PS_SUSP_CODE;
      end
      EDHC_OFS_OPMODE: begin
        rd_val[EDHC_OM_RX_START] = om_ff[0];
        rd_val[EDHC_OM_TX_START] = om_ff[1];
        rd_val[EDHC_OM_PORT_SEL] = om_ff[2];
        rd_val[EDHC_OM_TEN_MBPS] = om_ff[3];
      end
      EDHC_OFS_MASK: begin
        rd_val[EDHC_ST_RX_UNAVAIL] = mask_ff[0];
        rd_val[EDHC_ST_TX_UNAVAIL] = mask_ff[1];
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      prdata_ff  <= (psel & penable & ~pready_ff & ~pwrite) ? rd_val : 32'h0;
      pslverr_ff <= psel & penable & ~pready_ff & rd_err;
    end
  end

  // bus mode register and soft reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_mode_ff <= EDHC_BUS_MODE_RST;
      soft_rst_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      bus_mode_ff <= EDHC_BUS_MODE_RST;
      soft_rst_ff <= 1'b0;
    end else begin
      if (wr_en && paddr == EDHC_OFS_BUS_MODE)
        bus_mode_ff <= pwdata;
      soft_rst_ff <= wr_en & (paddr == EDHC_OFS_BUS_MODE) & pwdata[EDHC_BM_SOFT_RST];
    end
  end

  // list bases, operating mode, mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_base_ff <= 32'h0;
      tx_base_ff <= 32'h0;
      om_ff      <= 4'h0;
      mask_ff    <= 2'h0;
    end else if (soft_rst_ff) begin
      rx_base_ff <= 32'h0;
      tx_base_ff <= 32'h0;
      om_ff      <= {1'b0, om_ff[2], 2'b00};
      mask_ff    <= 2'h0;
    end else if (wr_en) begin
      if (paddr == EDHC_OFS_RX_BASE)
        rx_base_ff <= pwdata;
      if (paddr == EDHC_OFS_TX_BASE)
        tx_base_ff <= pwdata;
      if (paddr == EDHC_OFS_OPMODE)
        om_ff <= {pwdata[EDHC_OM_TEN_MBPS], pwdata[EDHC_OM_PORT_SEL],
                  pwdata[EDHC_OM_TX_START], pwdata[EDHC_OM_RX_START]};
      if (paddr == EDHC_OFS_MASK)
        mask_ff <= {pwdata[EDHC_ST_TX_UNAVAIL], pwdata[EDHC_ST_RX_UNAVAIL]};
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= 2'h0;
    end else if (soft_rst_ff) begin
      st_ff <= 2'h0;
    end else begin
      st_ff <= unavail_evt |
               (st_ff & ~({2{wr_en && paddr == EDHC_OFS_STATUS}} &
                          {pwdata[EDHC_ST_TX_UNAVAIL], pwdata[EDHC_ST_RX_UNAVAIL]}));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(st_ff & mask_ff);
  end

  // per-process state, fetch address and poll check
  for (genvar gi = 0; gi < 2; gi++) begin : g_proc
    edhc_proc_t state_ff;
    logic [31:0] addr_ff;
    logic        chk_ff;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_ff <= EDHC_PROC_STOP;
      end else if (soft_rst_ff) begin
        state_ff <= EDHC_PROC_STOP;
      end else begin
        case (state_ff)
          EDHC_PROC_STOP: begin
            if (start[gi])
              state_ff <= EDHC_PROC_RUN;
          end
          EDHC_PROC_RUN: begin
            if (!start[gi])
              state_ff <= EDHC_PROC_STOP;
            else if (list_empty[gi])
              state_ff <= EDHC_PROC_SUSP;
          end
          EDHC_PROC_SUSP: begin
            if (!start[gi])
              state_ff <= EDHC_PROC_STOP;
            else if (poll_dem[gi] && desc_avail[gi])
              state_ff <= EDHC_PROC_RUN;
          end
          default: state_ff <= EDHC_PROC_STOP;
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        addr_ff <= 32'h0;
      end else if (soft_rst_ff) begin
        addr_ff <= 32'h0;
      end else if (state_ff == EDHC_PROC_STOP && start[gi]) begin
        addr_ff <= base[gi];
      end else if (state_ff == EDHC_PROC_RUN && step[gi]) begin
        addr_ff <= chained[gi] ? chain_addr[gi]
                 : addr_ff + ((EDHC_DESC_LONGWORDS + {27'h0, descriptor_gap_longwords}) << 2);
      end
    end

    // acted-on poll demand, only while suspended
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        chk_ff <= 1'b0;
      else
        chk_ff <= ~soft_rst_ff & poll_dem[gi] & start[gi] & (state_ff == EDHC_PROC_SUSP);
    end

    // no flag when a poll finds nothing, only when a running list runs dry
    assign unavail_evt[gi] = (state_ff == EDHC_PROC_RUN) & start[gi] & list_empty[gi] & ~soft_rst_ff;
    assign fetch_addr[gi]  = addr_ff;
    assign proc_state[gi]  = state_ff;
    assign poll_chk[gi]    = chk_ff;

    property p_poll_ignored;
      @(posedge pclk) disable iff (!presetn)
      (poll_wr[gi] && state_ff != EDHC_PROC_SUSP) |=> !chk_ff;
    endproperty
    a_poll_ignored: assert property (p_poll_ignored) else $error("poll acted on outside suspend");

    property p_poll_empty;
      @(posedge pclk) disable iff (!presetn)
      (state_ff == EDHC_PROC_SUSP && start[gi] && poll_wr[gi] && !desc_avail[gi] && !soft_rst_ff
       && !st_ff[gi]) |=> (state_ff == EDHC_PROC_SUSP && !st_ff[gi] && chk_ff);
    endproperty
    a_poll_empty: assert property (p_poll_empty) else $error("empty poll left suspend or set flag");

    property p_poll_resume;
      @(posedge pclk) disable iff (!presetn)
      (state_ff == EDHC_PROC_SUSP && start[gi] && poll_wr[gi] && desc_avail[gi] && !soft_rst_ff)
      |=> state_ff == EDHC_PROC_RUN;
    endproperty
    a_poll_resume: assert property (p_poll_resume) else $error("poll with descriptor did not resume");

    property p_start_base;
      @(posedge pclk) disable iff (!presetn)
      (state_ff == EDHC_PROC_STOP && start[gi] && !soft_rst_ff) |=> addr_ff == $past(base[gi]);
    endproperty
    a_start_base: assert property (p_start_base) else $error("fetch did not begin at list base");

    property p_gap_step;
      @(posedge pclk) disable iff (!presetn)
      (state_ff == EDHC_PROC_RUN && start[gi] && step[gi] && !chained[gi] && !soft_rst_ff)
      |=> addr_ff == $past(addr_ff) + 32'h10 + ({27'h0, $past(descriptor_gap_longwords)} << 2);
    endproperty
    a_gap_step: assert property (p_gap_step) else $error("descriptor step ignores gap");
  end

  // internal bus arbitration
  always_comb begin
    nxt_gnt = gnt_ff;
    if ((gnt_ff == 2'b00) || (gnt_ff[0] && !rx_bus_req) || (gnt_ff[1] && !tx_bus_req)) begin
      if (rx_bus_req && tx_bus_req) begin
        if (bus_mode_ff[EDHC_BM_ARB_RR])
          nxt_gnt = last_rx_ff ? 2'b10 : 2'b01;
        else
          nxt_gnt = tx_in_progress ? 2'b10 : 2'b01;
      end else begin
        nxt_gnt = {tx_bus_req, rx_bus_req};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnt_ff     <= 2'b00;
      last_rx_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      gnt_ff     <= 2'b00;
      last_rx_ff <= 1'b0;
    end else begin
      gnt_ff <= nxt_gnt;
      if (nxt_gnt != gnt_ff && nxt_gnt != 2'b00)
        last_rx_ff <= nxt_gnt[0];
    end
  end

  property p_rr;
    @(posedge pclk) disable iff (!presetn)
    (gnt_ff == 2'b00 && rx_bus_req && tx_bus_req && bus_mode_ff[EDHC_BM_ARB_RR] && !soft_rst_ff)
    |=> gnt_ff == ($past(last_rx_ff) ? 2'b10 : 2'b01);
  endproperty
  a_rr: assert property (p_rr) else $error("round robin turn skipped");

  property p_rx_first;
    @(posedge pclk) disable iff (!presetn)
    (gnt_ff == 2'b00 && rx_bus_req && tx_bus_req && !bus_mode_ff[EDHC_BM_ARB_RR]
     && !tx_in_progress && !soft_rst_ff) |=> gnt_ff == 2'b01;
  endproperty
  a_rx_first: assert property (p_rx_first) else $error("receive priority not given");

  // transmit auto-poll: 320 ns ticks, interval by port mode and code
  always_comb begin
    if (!om_ff[2])
      ap_ticks = 15'(EDHC_TAP_SER_NS[bus_mode_ff[EDHC_BM_TAP_LO +: 3]] / EDHC_TICK_NS);
    else if (om_ff[3])
      ap_ticks = 15'(EDHC_TAP_M10_NS[bus_mode_ff[EDHC_BM_TAP_LO +: 3]] / EDHC_TICK_NS);
    else
      ap_ticks = 15'(EDHC_TAP_M100_NS[bus_mode_ff[EDHC_BM_TAP_LO +: 3]] / EDHC_TICK_NS);
  end

  assign tick = (tick_cnt_ff == 16'(POLL_TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff  <= 16'h0;
      ap_cnt_ff    <= 15'h0;
      auto_poll_ff <= 1'b0;
    end else if (soft_rst_ff || proc_state[1] != EDHC_PROC_SUSP || ap_ticks == 15'h0) begin
      tick_cnt_ff  <= 16'h0;
      ap_cnt_ff    <= 15'h0;
      auto_poll_ff <= 1'b0;
    end else begin
      tick_cnt_ff  <= tick ? 16'h0 : tick_cnt_ff + 16'h1;
      auto_poll_ff <= 1'b0;
      if (tick) begin
        if (ap_cnt_ff >= ap_ticks - 15'h1) begin
          ap_cnt_ff    <= 15'h0;
          auto_poll_ff <= 1'b1;
        end else begin
          ap_cnt_ff <= ap_cnt_ff + 15'h1;
        end
      end
    end
  end

  property p_tap_off;
    @(posedge pclk) disable iff (!presetn)
    (bus_mode_ff[EDHC_BM_TAP_LO +: 3] == 3'b000) |=> !auto_poll_ff;
  endproperty
  a_tap_off: assert property (p_tap_off) else $error("auto-poll while disabled");

  property p_tap_ser;
    @(posedge pclk) disable iff (!presetn)
    (tick && !om_ff[2] && bus_mode_ff[EDHC_BM_TAP_LO +: 3] == 3'b001 && proc_state[1] == EDHC_PROC_SUSP
     && !soft_rst_ff && ap_cnt_ff == 15'd624) |=> auto_poll_ff;
  endproperty
  a_tap_ser: assert property (p_tap_ser) else $error("serial 200 us interval wrong");

  property p_tap_m10;
    @(posedge pclk) disable iff (!presetn)
    (auto_poll_ff && om_ff[2] && om_ff[3] && bus_mode_ff[EDHC_BM_TAP_LO +: 3] == 3'b011)
    |-> $past(ap_cnt_ff) == 15'd19999;
  endproperty
  a_tap_m10: assert property (p_tap_m10) else $error("10 Mb/s 6.4 ms interval wrong");

  property p_tap_m100;
    @(posedge pclk) disable iff (!presetn)
    (auto_poll_ff && om_ff[2] && !om_ff[3] && bus_mode_ff[EDHC_BM_TAP_LO +: 3] == 3'b100)
    |-> $past(ap_cnt_ff) == 15'd15;
  endproperty
  a_tap_m100: assert property (p_tap_m100) else $error("100 Mb/s 5.12 us interval wrong");

  property p_auto_susp;
    @(posedge pclk) disable iff (!presetn)
    auto_poll_ff |-> $past(proc_state[1]) == EDHC_PROC_SUSP;
  endproperty
  a_auto_susp: assert property (p_auto_susp) else $error("auto-poll outside transmit suspend");

  property p_soft_rst;
    @(posedge pclk) disable iff (!presetn)
    soft_rst_ff |=> (bus_mode_ff == EDHC_BUS_MODE_RST && om_ff[2] == $past(om_ff[2]) && om_ff[1:0] == 2'b00
                     && proc_state[0] == EDHC_PROC_STOP && proc_state[1] == EDHC_PROC_STOP && st_ff == 2'b00);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete or port select lost");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == EDHC_OFS_BUS_MODE && !soft_rst_ff) |=> cache_align == $past(pwdata[15:14]);
  endproperty
  a_align: assert property (p_align) else $error("cache alignment not taken");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    (st_ff[1] && !soft_rst_ff && !(wr_en && paddr == EDHC_OFS_STATUS && pwdata[EDHC_ST_TX_UNAVAIL]))
    |=> st_ff[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without write of one");

  assign prdata                   = prdata_ff;
  assign pready                   = pready_ff;
  assign pslverr                  = pslverr_ff;
  assign irq                      = irq_ff;
  assign rx_bus_gnt               = gnt_ff[0];
  assign tx_bus_gnt               = gnt_ff[1];
  assign rx_fetch_addr            = fetch_addr[0];
  assign tx_fetch_addr            = fetch_addr[1];
  assign rx_poll_check            = poll_chk[0];
  assign tx_poll_check            = poll_chk[1];
  assign rx_proc_state            = proc_state[0];
  assign tx_proc_state            = proc_state[1];
  assign cache_align              = bus_mode_ff[EDHC_BM_ALIGN_LO +: 2];
  assign descriptor_gap_longwords = bus_mode_ff[EDHC_BM_GAP_LO +: 5];
  assign dma_soft_reset           = soft_rst_ff;

endmodule // edhc_dma_host_ctrl
`default_nettype wire

// file: hdl/edhc_pkg.sv
// constants and types of the dma host control block
package edhc_pkg;

  localparam int unsigned EDHC_CLK_NS = 8;

  // register byte offsets
  localparam logic [7:0] EDHC_OFS_BUS_MODE = 8'h00;
  localparam logic [7:0] EDHC_OFS_TX_POLL  = 8'h08;
  localparam logic [7:0] EDHC_OFS_RX_POLL  = 8'h10;
  localparam logic [7:0] EDHC_OFS_RX_BASE  = 8'h18;
  localparam logic [7:0] EDHC_OFS_TX_BASE  = 8'h20;
  localparam logic [7:0] EDHC_OFS_STATUS   = 8'h28;
  localparam logic [7:0] EDHC_OFS_OPMODE   = 8'h30;
  localparam logic [7:0] EDHC_OFS_MASK     = 8'h38;

  // bus mode fields
  localparam int unsigned EDHC_BM_SOFT_RST = 0;
  localparam int unsigned EDHC_BM_ARB_RR   = 1;
  localparam int unsigned EDHC_BM_GAP_LO   = 2;
  localparam int unsigned EDHC_BM_ALIGN_LO = 14;
  localparam int unsigned EDHC_BM_TAP_LO   = 17;

  localparam logic [31:0] EDHC_BUS_MODE_RST = 32'hfe000000;
  localparam logic [31:0] EDHC_POLL_RD_VAL  = 32'h0fffffff;

  // operating mode fields
  localparam int unsigned EDHC_OM_RX_START = 1;
  localparam int unsigned EDHC_OM_TX_START = 13;
  localparam int unsigned EDHC_OM_PORT_SEL = 18;
  localparam int unsigned EDHC_OM_TEN_MBPS = 22;

  // status fields
  localparam int unsigned EDHC_ST_TX_UNAVAIL = 2;
  localparam int unsigned EDHC_ST_RX_UNAVAIL = 7;
  localparam int unsigned EDHC_ST_RX_STATE   = 17;
  localparam int unsigned EDHC_ST_TX_STATE   = 20;

  localparam logic [2:0] EDHC_PS_STOP_CODE = 3'h0;
  localparam logic [2:0] EDHC_PS_RUN_CODE  = 3'h3;
  localparam logic [2:0] EDHC_PS_SUSP_CODE = 3'h6;

  localparam logic [31:0] EDHC_DESC_LONGWORDS = 32'h4;

  // auto-poll time base and intervals in ns, entry 0 means disabled
  localparam int unsigned EDHC_TICK_NS  = 320;
  localparam int unsigned EDHC_TICK_CYC = EDHC_TICK_NS / EDHC_CLK_NS;
  localparam int unsigned EDHC_TAP_SER_NS [8] =
    '{0, 200000, 800000, 1600000, 12800, 25600, 51200, 102400};
  localparam int unsigned EDHC_TAP_M10_NS [8] =
    '{0, 800000, 3200000, 6400000, 51200, 102400, 204800, 409600};
  localparam int unsigned EDHC_TAP_M100_NS [8] =
    '{0, 8000, 320000, 640000, 5120, 10240, 20480, 40960};

  typedef enum logic [2:0] {
    EDHC_PROC_STOP = 3'b001,
    EDHC_PROC_RUN  = 3'b010,
    EDHC_PROC_SUSP = 3'b100
  } edhc_proc_t;

endpackage

// file: tb/edhc_dma_model.sv
// partner model: dma fetch processes driven by bench commands
`timescale 1ns/100ps
`default_nettype none
module edhc_dma_model (
  input  wire logic        pclk,
  output wire logic        rx_desc_avail,
  output wire logic        tx_desc_avail,
  output wire logic        rx_list_empty,
  output wire logic        tx_list_empty,
  output wire logic        rx_desc_step,
  output wire logic        tx_desc_step,
  output wire logic        rx_desc_chained,
  output wire logic        tx_desc_chained,
  output wire logic        rx_bus_req,
  output wire logic        tx_bus_req,
  output wire logic        tx_in_progress,
  output wire logic [31:0] rx_chain_addr,
  output wire logic [31:0] tx_chain_addr
);
  logic [10:0] ctl_ff = 11'h000;
  assign {tx_in_progress, tx_bus_req, rx_bus_req, tx_desc_chained, rx_desc_chained} = ctl_ff[10:6];
  assign {tx_desc_step, rx_desc_step, tx_list_empty, rx_list_empty} = ctl_ff[5:2];
  assign {tx_desc_avail, rx_desc_avail} = ctl_ff[1:0];
  // chained lists on longword boundaries
  assign rx_chain_addr = 32'h00003000;
  assign tx_chain_addr = 32'h00004000;
  // one-cycle event, step may carry the chained flag
  task automatic pulse(input int b, input logic c);
    ctl_ff[b] <= 1'b1;
    ctl_ff[b+2] <= c;
    @(posedge pclk);
    ctl_ff[b] <= 1'b0;
    ctl_ff[b+2] <= 1'b0;
  endtask
endmodule // edhc_dma_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the dma host control block
`timescale 1ns/100ps
`default_nettype none
module tb
  import edhc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rdat;
  logic        rerr;
  logic [7:0]  n;
  int          k;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [7:0]  rpc = 8'h00;
  logic [7:0]  tpc = 8'h00;
  logic [7:0]  spc = 8'h00;
  wire logic [31:0] prdata, rx_fetch_addr, tx_fetch_addr, rx_chain_addr, tx_chain_addr;
  wire logic [2:0]  rx_proc_state, tx_proc_state;
  wire logic [1:0]  cache_align;
  wire logic [4:0]  descriptor_gap_longwords;
  wire logic pready, pslverr, irq, rx_desc_avail, tx_desc_avail, rx_list_empty, tx_list_empty;
  wire logic rx_desc_step, tx_desc_step, rx_desc_chained, tx_desc_chained, rx_bus_req, tx_bus_req;
  wire logic tx_in_progress, rx_bus_gnt, tx_bus_gnt, rx_poll_check, tx_poll_check, dma_soft_reset;
  always #4 pclk = ~pclk;
  // pulse counters
  always @(posedge pclk) begin
    rpc <= rpc + 8'(rx_poll_check === 1'b1);
    tpc <= tpc + 8'(tx_poll_check === 1'b1);
    spc <= spc + 8'(dma_soft_reset === 1'b1);
  end
  edhc_dma_host_ctrl #(.POLL_TICK_CYC(1)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .rx_desc_avail, .tx_desc_avail, .rx_list_empty,
    .tx_list_empty, .rx_desc_step, .tx_desc_step, .rx_desc_chained, .tx_desc_chained, .rx_chain_addr,
    .tx_chain_addr, .rx_bus_req, .tx_bus_req, .tx_in_progress, .rx_bus_gnt, .tx_bus_gnt, .rx_fetch_addr,
    .tx_fetch_addr, .rx_poll_check, .tx_poll_check, .rx_proc_state, .tx_proc_state, .cache_align,
    .descriptor_gap_longwords, .dma_soft_reset);
  edhc_dma_model dma_u (.pclk, .rx_desc_avail, .tx_desc_avail, .rx_list_empty, .tx_list_empty,
    .rx_desc_step, .tx_desc_step, .rx_desc_chained, .tx_desc_chained, .rx_bus_req, .tx_bus_req,
    .tx_in_progress, .rx_chain_addr, .tx_chain_addr);
  task automatic close_out();
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // cycles between two auto polls, first gap skipped
  task automatic poll_gap(input int e);
    for (int j = 0; j < 2; j++) begin
      n = tpc;
      k = 0;
      while (tpc === n && k < 1000) begin
        cyc(1);
        k++;
      end
    end
    chk(k, e);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic arb(input logic ip, input logic [1:0] e);
    dma_u.ctl_ff[10:8] <= {ip, 2'b11};
    cyc(3);
    chk(32'({rx_bus_gnt, tx_bus_gnt}), 32'(e));
    dma_u.ctl_ff[10:8] <= 3'b000;
    cyc(3);
  endtask
  initial begin
    cyc(5000);
    error_cnt++;
    close_out();
  end
  initial begin
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    rd(EDHC_OFS_BUS_MODE, EDHC_BUS_MODE_RST);
    rd(EDHC_OFS_TX_POLL, EDHC_POLL_RD_VAL);
    rd(EDHC_OFS_RX_POLL, EDHC_POLL_RD_VAL);
    apb(1'b1, 8'h3c, 32'h1);
    chk(32'(rerr), 32'h1);
    wr(EDHC_OFS_BUS_MODE, 32'h0);
    arb(1'b1, 2'b01);
    arb(1'b0, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(EDHC_OFS_BUS_MODE, 32'h0002000e | (i << 14));
      chk(32'(cache_align), i);
    end
    chk(32'(descriptor_gap_longwords), 32'h3);
    rd(EDHC_OFS_BUS_MODE, 32'h0002c00e);
    arb(1'b0, 2'b01);
    wr(EDHC_OFS_RX_BASE, 32'h00001000);
    wr(EDHC_OFS_TX_BASE, 32'h00002000);
    rd(EDHC_OFS_TX_BASE, 32'h00002000);
    wr(EDHC_OFS_TX_POLL, 32'h0);
    wr(EDHC_OFS_RX_POLL, 32'h0);
    cyc(2);
    chk(32'({rpc, tpc}), 32'h0);
    wr(EDHC_OFS_MASK, 32'h00000084);
    wr(EDHC_OFS_OPMODE, 32'h00002002);
    cyc(1);
    chk(rx_fetch_addr, 32'h00001000);
    chk(tx_fetch_addr, 32'h00002000);
    wr(EDHC_OFS_RX_POLL, 32'h0);
    cyc(2);
    chk(32'(rpc), 32'h0);
    dma_u.pulse(4, 1'b0);
    dma_u.pulse(5, 1'b1);
    cyc(1);
    chk(rx_fetch_addr, 32'h0000101c);
    chk(tx_fetch_addr, 32'h00004000);
    dma_u.pulse(2, 1'b0);
    dma_u.pulse(3, 1'b0);
    cyc(1);
    chk(32'(irq), 32'h1);
    rd(EDHC_OFS_STATUS, 32'h006c0084);
    rd(EDHC_OFS_STATUS, 32'h006c0084);
    wr(EDHC_OFS_STATUS, 32'h0);
    rd(EDHC_OFS_STATUS, 32'h006c0084);
    wr(EDHC_OFS_STATUS, 32'h00000004);
    rd(EDHC_OFS_STATUS, 32'h006c0080);
    wr(EDHC_OFS_MASK, 32'h00000004);
    cyc(1);
    chk(32'(irq), 32'h0);
    wr(EDHC_OFS_MASK, 32'h00000080);
    cyc(1);
    chk(32'(irq), 32'h1);
    wr(EDHC_OFS_STATUS, 32'h00000080);
    cyc(1);
    chk(32'(irq), 32'h0);
    wr(EDHC_OFS_RX_POLL, 32'h0);
    cyc(2);
    chk(32'(rpc), 32'h1);
    rd(EDHC_OFS_STATUS, 32'h006c0000);
    dma_u.ctl_ff[0] <= 1'b1;
    wr(EDHC_OFS_RX_POLL, 32'h0);
    cyc(2);
    chk(32'(rx_proc_state), 32'(EDHC_PROC_RUN));
    // serial mode code 001: 625 ticks between auto polls
    poll_gap(625);
    dma_u.ctl_ff[1] <= 1'b1;
    wr(EDHC_OFS_TX_POLL, 32'h0);
    cyc(2);
    chk(32'(tx_proc_state), 32'(EDHC_PROC_RUN));
    wr(EDHC_OFS_OPMODE, 32'h00040000);
    wr(EDHC_OFS_BUS_MODE, 32'h00000001);
    cyc(3);
    chk(32'(spc), 32'h1);
    rd(EDHC_OFS_BUS_MODE, EDHC_BUS_MODE_RST);
    rd(EDHC_OFS_RX_BASE, 32'h0);
    rd(EDHC_OFS_OPMODE, 32'h00040000);
    chk(32'(tx_proc_state), 32'(EDHC_PROC_STOP));
    // 100 Mb/s mii kept over soft reset, code 100: 16 ticks
    dma_u.ctl_ff[1] <= 1'b0;
    wr(EDHC_OFS_BUS_MODE, 32'h00080000);
    wr(EDHC_OFS_OPMODE, 32'h00042000);
    dma_u.pulse(3, 1'b0);
    poll_gap(16);
    close_out();
  end
endmodule // tb
`default_nettype wire
